// [rtl/port_io_crossbar_config.sv]
// Port pin configuration and priority crossbar routing
`timescale 1ns/1ps
`default_nettype none
module port_io_crossbar_config
  import port_io_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst,
  // Configuration, held by the core's special-function registers
  input  wire logic [NPINS-1:0]    port_input_mode_reg,
  input  wire logic [NPINS-1:0]    port_output_mode_reg,
  input  wire logic [NXPINS-1:0]   crossbar_skip_reg,
  input  wire logic [NPINS-1:0]    port_latch_wr,
  input  wire logic [7:0]          crossbar_select_first,
  input  wire logic [7:0]          crossbar_select_second,
  input  wire logic [7:0]          crossbar_select_third,
  input  wire logic [NBANKS-1:0]   bank_drive_sel,
  // Peripheral side
  input  wire logic [NSIG-1:0]     periph_out,
  input  wire logic [NSIG-1:0]     periph_drive,
  output logic [NSIG-1:0]          periph_in,
  // Debug data line sharing the first third-bank pin
  input  wire logic                debug_active,
  input  wire logic                debug_data_out,
  input  wire logic                debug_data_drive,
  output logic                     debug_data_in,
  // Port latch read-back
  output logic [NPINS-1:0]         port_latch_rd,
  // Pad side
  input  wire logic [NPINS-1:0]    pin_in,
  output logic [NPINS-1:0]         pin_out,
  output logic [NPINS-1:0]         pin_oe_n,
  output logic [NPINS-1:0]         pin_pullup_en,
  output logic [NPINS-1:0]         pin_analog_en,
  output logic [NBANKS-1:0]        bank_drive_high
);

  // Two-stage synchroniser; stage one feeds stage two only
  logic [NPINS-1:0] pin_meta;
  logic [NPINS-1:0] pin_sync;
  // Not reset: both stages flush within two edges of any pad level

  // Stage one may go metastable, so only stage two reads it
  always_ff @(posedge clk)
  begin
    pin_meta <= pin_in;
  end

  // Stage two gives the settled copy that every reader uses
  always_ff @(posedge clk)
  begin
    pin_sync <= pin_meta;
  end

  // Global controls
  // Select bits are read live; software owns the order of set-up
  wire xbar_on    = crossbar_select_third[SEL3_XBAR];
  wire pud        = crossbar_select_second[SEL2_PUD];
  wire [1:0] pca_n = crossbar_select_second[SEL2_PCA_HI:SEL2_PCA_LO];
  wire uart_on    = crossbar_select_first[SEL1_UART];
  wire spi_on     = crossbar_select_first[SEL1_SPI];
  wire smb_on     = crossbar_select_first[SEL1_SMB];

  // Per-signal enables from the select registers
  wire [NSIG-1:0] sig_en;
  assign sig_en[SIG_UTX]  = uart_on;
  assign sig_en[SIG_URX]  = uart_on;
  assign sig_en[SIG_SCK]  = spi_on;
  assign sig_en[SIG_MISO] = spi_on;
  assign sig_en[SIG_MOSI] = spi_on;
  assign sig_en[SIG_NSS]  = spi_on & crossbar_select_third[SEL3_SPI4W];
  assign sig_en[SIG_SDA]  = smb_on;
  assign sig_en[SIG_SCL]  = smb_on;
  assign sig_en[SIG_CP0]  = crossbar_select_first[SEL1_CP0];
  assign sig_en[SIG_CP0A] = crossbar_select_first[SEL1_CP0A];
  assign sig_en[SIG_CP1]  = crossbar_select_first[SEL1_CP1];
  assign sig_en[SIG_CP1A] = crossbar_select_first[SEL1_CP1A];
  assign sig_en[SIG_SYSCLK] = crossbar_select_first[SEL1_SYSCLK];
  assign sig_en[SIG_ECI]  = crossbar_select_second[SEL2_ECI];
  assign sig_en[SIG_T0]   = crossbar_select_second[SEL2_T0];
  assign sig_en[SIG_T1]   = crossbar_select_second[SEL2_T1];
  assign sig_en[SIG_T2]   = crossbar_select_second[SEL2_T2];

  // Capture/compare outputs enabled by channel count
  // The channel count reaches as many channels as sit before ECI
  localparam int NCEX = SIG_ECI - SIG_CEX0;
  genvar c;
  generate
    for (c = 0; c < NCEX; c++)
    begin : g_cex
      assign sig_en[SIG_CEX0 + c] = (32'(pca_n) > c);
    end
  endgenerate

  // Priority decoder: walk signals after the serial port in order, give each the lowest free pin.
  // Skipped pins start out taken so they are passed over like claimed ones.
  logic [NXPINS-1:0] taken;
  logic [3:0]        sig_pin [NSIG];
  logic [NSIG-1:0]   sig_ok;
  logic [4:0]        pin_sig [NXPINS];
  logic [NXPINS-1:0] pin_ok;
  logic              found;

  // Bus line test for the open-drain override.
  // Kept apart so the bus signal indices are named in one place.
  function automatic logic is_bus_line(input logic [4:0] sig);
    is_bus_line = (sig == 5'(SIG_SDA)) | (sig == 5'(SIG_SCL));
  endfunction

  always_comb
  begin
    taken  = crossbar_skip_reg;
    sig_ok = '0;
    pin_ok = '0;
    found  = 1'b0;
    // Unused entries read as zero and are masked by sig_ok or pin_ok
    for (int s = 0; s < NSIG; s++)
      sig_pin[s] = 4'h0;
    for (int p = 0; p < NXPINS; p++)
      pin_sig[p] = 5'h00;
    // Serial port is pinned regardless of skips
    if (uart_on)
    begin
      taken[UART_TX_PIN] = 1'b1;
      taken[UART_RX_PIN] = 1'b1;
      sig_pin[SIG_UTX]   = UART_TX_PIN;
      sig_pin[SIG_URX]   = UART_RX_PIN;
      sig_ok[SIG_UTX]    = 1'b1;
      sig_ok[SIG_URX]    = 1'b1;
    end
    // A signal finding no free pin stays unassigned; software must
    // count its pins, nothing here flags the shortage
    for (int s = SIG_SCK; s < NSIG; s++)
    begin
      found = 1'b0;
      if (sig_en[s])
      begin
        for (int p = 0; p < NXPINS; p++)
        begin
          if (!found && !taken[p])
          begin
            found      = 1'b1;
            taken[p]   = 1'b1;
            sig_pin[s] = 4'(p);
            sig_ok[s]  = 1'b1;
          end
        end
      end
    end
    // Reverse map: which signal owns each pin
    for (int s = 0; s < NSIG; s++)
    begin
      if (sig_ok[s])
      begin
        pin_sig[sig_pin[s]] = 5'(s);
        pin_ok[sig_pin[s]]  = 1'b1;
      end
    end
  end

  // Per-pin drive decisions
  logic [NPINS-1:0] digital;
  logic [NPINS-1:0] routed;
  logic [NPINS-1:0] value;
  logic [NPINS-1:0] want_drive;
  logic [NPINS-1:0] open_drain;
  logic [NPINS-1:0] drive_on;
  logic [NPINS-1:0] next_pullup;
  logic [NPINS-1:0] pad_drive;

  assign digital = port_input_mode_reg;

  // Debug line overrides the enable check so debugging works before set-up.
  // Trade-off: debug wins over any GPIO use of that pin while active.
  // It also ignores the output mode, so it may drive a one hard.
  wire dbg_drive = debug_active & debug_data_drive & digital[DEBUG_PIN];

  genvar i;
  generate
    for (i = 0; i < NPINS; i++)
    begin : g_pin
      if (i < NXPINS)
      begin : g_xbar
        // Routing only counts once the crossbar is on
        assign routed[i] = xbar_on & pin_ok[i];
        assign value[i] = routed[i] ? periph_out[pin_sig[i]]
                                    : port_latch_wr[i];
        assign want_drive[i] = routed[i] ? periph_drive[pin_sig[i]]
                                         : 1'b1;
        // Bus lines override the mode register
        assign open_drain[i] = ~port_output_mode_reg[i] |
          (routed[i] & is_bus_line(pin_sig[i]));
      end
      else
      begin : g_gpio
        // Third bank never joins the crossbar
        assign routed[i] = 1'b0;
        assign value[i] = (i == DEBUG_PIN && debug_active) ?
                          debug_data_out : port_latch_wr[i];
        assign want_drive[i] = (i == DEBUG_PIN && debug_active) ?
                               debug_data_drive : 1'b1;
        assign open_drain[i] = ~port_output_mode_reg[i];
      end
      // No driver while crossbar off or pin analog; open-drain drives low only
      assign drive_on[i] = xbar_on & digital[i] & want_drive[i] &
                           (~open_drain[i] | ~value[i]);
      // Pad drive as the pull-up sees it, debug override included
      assign pad_drive[i] = drive_on[i] | ((i == DEBUG_PIN) & dbg_drive);
      // Pull-up on open-drain digital pins unless disabled or pulling low
      assign next_pullup[i] = digital[i] & open_drain[i] & ~pud &
                              ~(pad_drive[i] & ~value[i]);
    end
  endgenerate

  // Pad drive value, low in reset so nothing glitches at power-up
  always_ff @(posedge clk)
  begin
    if (rst)
      pin_out <= '0;
    else
      pin_out <= value;
  end

  // Output enables, active low; reset releases every pad
  always_ff @(posedge clk)
  begin
    if (rst)
      pin_oe_n <= '1;
    else
      pin_oe_n <= ~pad_drive;
  end

  // Weak pull-ups follow the pad drive decided this cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      pin_pullup_en <= '0;
    else
      pin_pullup_en <= next_pullup;
  end

  // Analog switches follow the inverted input mode bits
  always_ff @(posedge clk)
  begin
    if (rst)
      pin_analog_en <= '0;
    else
      pin_analog_en <= ~digital;
  end

  // Bank drive strength, two levels per bank.
  // Registered so the pad slew control never sees a select glitch.
  always_ff @(posedge clk)
  begin
    if (rst)
      bank_drive_high <= '0;
    else
      bank_drive_high <= bank_drive_sel;
  end

  // Input receivers: analog pins read low since the receiver is off.
  // Gating here keeps a floating analog pad away from every reader.
  wire [NPINS-1:0] rx = pin_sync & digital;

  // Peripheral inputs follow the pin each signal owns;
  // a signal without a pin reads low, never a stale pin
  logic [NSIG-1:0] next_periph_in;
  generate
    for (i = 0; i < NSIG; i++)
    begin : g_sig
      assign next_periph_in[i] = xbar_on & sig_ok[i] & rx[sig_pin[i]];
    end
  endgenerate

  // Latch reads show the pin level whatever the routing
  always_ff @(posedge clk)
  begin
    if (rst)
      port_latch_rd <= '0;
    else
      port_latch_rd <= rx;
  end

  // Peripheral inputs, registered once more after the synchroniser
  always_ff @(posedge clk)
  begin
    if (rst)
      periph_in <= '0;
    else
      periph_in <= next_periph_in;
  end

  // Debug data read-back shares the same settled copy
  always_ff @(posedge clk)
  begin
    if (rst)
      debug_data_in <= 1'b0;
    else
      debug_data_in <= rx[DEBUG_PIN];
  end

endmodule
`default_nettype wire

// [rtl/port_io_pkg.sv]
// Constants for the port I/O and priority crossbar block
package port_io_pkg;
  localparam int NPINS  = 18;          // All pins, banks 0..2
  localparam int NXPINS = 16;          // Crossbar-capable pins
  localparam int NSIG   = 20;          // Routable peripheral signals
  localparam int NBANKS = 3;
  localparam int BANK_W = 8;           // Pins per bank
  localparam int DEBUG_PIN = 16;       // First pin of the third bank

  // Fixed serial port pins
  localparam logic [3:0] UART_TX_PIN = 4'h4;
  localparam logic [3:0] UART_RX_PIN = 4'h5;

  // Signal indices in priority order
  localparam int SIG_UTX  = 0;
  localparam int SIG_URX  = 1;
  localparam int SIG_SCK  = 2;
  localparam int SIG_MISO = 3;
  localparam int SIG_MOSI = 4;
  localparam int SIG_NSS  = 5;
  localparam int SIG_SDA  = 6;
  localparam int SIG_SCL  = 7;
  localparam int SIG_CP0  = 8;
  localparam int SIG_CP0A = 9;
  localparam int SIG_CP1  = 10;
  localparam int SIG_CP1A = 11;
  localparam int SIG_SYSCLK = 12;
  localparam int SIG_CEX0 = 13;
  localparam int SIG_ECI  = 16;
  localparam int SIG_T0   = 17;
  localparam int SIG_T1   = 18;
  localparam int SIG_T2   = 19;

  // First select register bit positions
  localparam int SEL1_UART   = 0;
  localparam int SEL1_SPI    = 1;
  localparam int SEL1_SMB    = 2;
  localparam int SEL1_CP0    = 3;
  localparam int SEL1_CP0A   = 4;
  localparam int SEL1_CP1    = 5;
  localparam int SEL1_CP1A   = 6;
  localparam int SEL1_SYSCLK = 7;
  // Second select register bit positions
  localparam int SEL2_PCA_LO = 0;      // Two-bit CEX channel count
  localparam int SEL2_PCA_HI = 1;
  localparam int SEL2_ECI    = 2;
  localparam int SEL2_T0     = 3;
  localparam int SEL2_T1     = 4;
  localparam int SEL2_T2     = 5;
  localparam int SEL2_PUD    = 7;      // Weak pull-up disable
  // Third select register bit positions
  localparam int SEL3_SPI4W  = 0;      // Route the SPI slave-select line
  localparam int SEL3_XBAR   = 6;      // Crossbar global enable

  // Reset values: every pin digital input, crossbar off
  localparam logic [NPINS-1:0] INPUT_MODE_RESET = 18'h3FFFF;
endpackage

// [verification/port_io_sva.sv]
// Checker for the port pin block, bound to the block's ports
`timescale 1ns/1ps
`default_nettype none
module port_io_sva
  import port_io_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [NPINS-1:0]  port_input_mode_reg,
  input  wire logic [NPINS-1:0]  port_output_mode_reg,
  input  wire logic [7:0]        crossbar_select_first,
  input  wire logic [7:0]        crossbar_select_second,
  input  wire logic [7:0]        crossbar_select_third,
  input  wire logic [NSIG-1:0]   periph_out,
  input  wire logic [NSIG-1:0]   periph_drive,
  input  wire logic              debug_active,
  input  wire logic              debug_data_out,
  input  wire logic              debug_data_drive,
  input  wire logic [NPINS-1:0]  port_latch_rd,
  input  wire logic [NPINS-1:0]  pin_in,
  input  wire logic [NPINS-1:0]  pin_out,
  input  wire logic [NPINS-1:0]  pin_oe_n,
  input  wire logic [NPINS-1:0]  pin_pullup_en,
  input  wire logic [NPINS-1:0]  pin_analog_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Pads steady over the synchroniser depth
  sequence quiet_pins;
    ($stable(pin_in) && $stable(port_input_mode_reg)) [*3];
  endsequence
  // Routing on, UART chosen, transmit pin digital and push-pull
  sequence uart_push;
    crossbar_select_third[SEL3_XBAR] && crossbar_select_first[SEL1_UART] &&
    periph_drive[SIG_UTX] && (port_output_mode_reg[4] && port_input_mode_reg[4]);
  endsequence
  // Pin behaviour checks
  AST_ANALOG_QUIET: assert property
    ((pin_analog_en & (~pin_oe_n | pin_pullup_en)) == '0)
    else $error("analog pin driven or pulled up");
  AST_MODE_MAP: assert property
    (!$past(rst) |-> pin_analog_en == ~$past(port_input_mode_reg))
    else $error("analog enable does not follow input mode");
  AST_XBAR_OFF: assert property
    (!crossbar_select_third[SEL3_XBAR] |=> &pin_oe_n[15:0])
    else $error("pin driven with crossbar off");
  AST_PULL_ZERO: assert property
    ((pin_pullup_en & ~pin_oe_n & ~pin_out) == '0)
    else $error("pull-up on while driving low");
  AST_PUD_OFF: assert property
    (crossbar_select_second[SEL2_PUD] |=> pin_pullup_en == '0)
    else $error("pull-up on while disabled");
  AST_LATCH_RD: assert property
    (quiet_pins ##0 !$past(rst) |->
     port_latch_rd == (pin_in & port_input_mode_reg))
    else $error("latch read differs from pad level");
  AST_UART_TX: assert property
    (uart_push |=> !pin_oe_n[UART_TX_PIN] &&
     pin_out[UART_TX_PIN] == $past(periph_out[SIG_UTX]))
    else $error("transmit not on its fixed pin");
  AST_DEBUG_DRV: assert property
    (debug_active && debug_data_drive && port_input_mode_reg[DEBUG_PIN]
     |=> !pin_oe_n[DEBUG_PIN] && pin_out[DEBUG_PIN] == $past(debug_data_out))
    else $error("debug data not driven on its pin");
  AST_OD_NO_HIGH: assert property
    (!$past(rst) |-> (~pin_oe_n & pin_out & 18'h2FFFF &
     ~$past(port_output_mode_reg)) == '0)
    else $error("open-drain pin drives high");
endmodule
bind port_io_crossbar_config port_io_sva u_sva
(
  .clk, .rst, .port_input_mode_reg, .port_output_mode_reg,
  .crossbar_select_first, .crossbar_select_second, .crossbar_select_third,
  .periph_out, .periph_drive, .debug_active, .debug_data_out,
  .debug_data_drive, .port_latch_rd, .pin_in, .pin_out, .pin_oe_n,
  .pin_pullup_en, .pin_analog_en
);
`default_nettype wire

// [verification/pad_model.sv]
// Pad model resolving each pin from block, outside driver and pull-up
`timescale 1ns/1ps
`default_nettype none
module pad_model
  import port_io_pkg::*;
(
  input  wire logic [NPINS-1:0]  pin_out,
  input  wire logic [NPINS-1:0]  pin_oe_n,
  input  wire logic [NPINS-1:0]  pin_pullup_en,
  input  wire logic [NPINS-1:0]  ext_val,
  input  wire logic [NPINS-1:0]  ext_drive,
  input  wire logic              clk,
  output logic      [NPINS-1:0]  pin_in
);
  logic [NPINS-1:0] float_pat = 18'h15555;
  // A floating pad wanders, so no stale level can pass for a real one
  always @(posedge clk)
  begin
    float_pat <= ~float_pat;
  end
  // Block driver first, then outside driver, then pull-up or float
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_drive & ext_val) |
                  (pin_oe_n & ~ext_drive & (pin_pullup_en | float_pat));
endmodule
`default_nettype wire

// [verification/port_io_crossbar_config_tb_top.sv]
// Self-checking bench for the port pin and crossbar block
`timescale 1ns/1ps
`default_nettype none
module port_io_crossbar_config_tb_top;
  import port_io_pkg::*;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic [NPINS-1:0]   port_input_mode_reg, port_output_mode_reg, port_latch_wr;
  logic [NPINS-1:0]   pin_in, pin_out, pin_oe_n, pin_pullup_en, pin_analog_en;
  logic [NPINS-1:0]   port_latch_rd, ext_val, ext_drive;
  logic [NXPINS-1:0]  crossbar_skip_reg;
  logic [7:0]         crossbar_select_first, crossbar_select_second;
  logic [7:0]         crossbar_select_third;
  logic [NBANKS-1:0]  bank_drive_sel, bank_drive_high;
  logic [NSIG-1:0]    periph_out, periph_drive, periph_in;
  logic               debug_active, debug_data_out, debug_data_drive;
  logic               debug_data_in;
  int                 err_total = 0;
  int                 tests_run = 0;
  port_io_crossbar_config uut
  (
    .clk, .rst, .port_input_mode_reg, .port_output_mode_reg,
    .crossbar_skip_reg, .port_latch_wr, .crossbar_select_first,
    .crossbar_select_second, .crossbar_select_third, .bank_drive_sel,
    .periph_out, .periph_drive, .periph_in, .debug_active, .debug_data_out,
    .debug_data_drive, .debug_data_in, .port_latch_rd, .pin_in, .pin_out,
    .pin_oe_n, .pin_pullup_en, .pin_analog_en, .bank_drive_high
  );
  pad_model pads
  (
    .clk, .pin_out, .pin_oe_n, .pin_pullup_en, .ext_val, .ext_drive, .pin_in
  );
  always #10 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // New setup at the falling edge; six cycles cover the synchroniser
  task automatic cfg(input logic [17:0] im, om, input logic [15:0] sk,
                     input logic [7:0] s1, s2, s3);
    @(negedge clk);
    port_input_mode_reg = im;
    port_output_mode_reg = om;
    crossbar_skip_reg = sk;
    crossbar_select_first = s1;
    crossbar_select_second = s2;
    crossbar_select_third = s3;
    repeat (6) @(negedge clk);
  endtask
  task automatic t_reset;
    check(pin_oe_n, 18'h3FFFF);
    check(periph_in, 20'h00000);
    check(pin_analog_en, 18'h00000);
    check(pin_pullup_en, 18'h3FFFF);
    check(port_latch_rd, 18'h3FFFF);
    $display("test reset done");
  endtask
  // UART and 4-wire SPI with one pin skipped, then a second skip
  task automatic t_walk;
    periph_drive = 20'h00035;
    ext_drive = 18'h00022;
    ext_val = 18'h00002;
    cfg(18'h3FFFF, 18'h3FFFF, 16'h0008, 8'h03, 8'h00, 8'h01);
    check(pin_oe_n, 18'h3FFFF);
    cfg(18'h3FFFF, 18'h3FFFF, 16'h0008, 8'h03, 8'h00, 8'h41);
    check(pin_oe_n, 18'h00022);
    check(pin_out & 18'h3FFDD, (port_latch_wr & 18'h3FF88) | 18'h00055);
    check(periph_in, 20'h0003D);
    ext_drive = 18'h00024;
    ext_val = 18'h00004;
    cfg(18'h3FFFF, 18'h3FFFF, 16'h0009, 8'h03, 8'h00, 8'h41);
    check(pin_oe_n, 18'h00024);
    $display("test crossbar walk done");
  endtask
  // Management bus pins stay open-drain on push-pull settings
  task automatic t_smbus;
    periph_drive = 20'h000C0;
    ext_drive = 18'h00000;
    cfg(18'h3FFFF, 18'h3FFFF, 16'h0000, 8'h04, 8'h00, 8'h40);
    check(pin_oe_n, 18'h00003);
    check(pin_pullup_en, 18'h00003);
    periph_out = 20'h00000;
    repeat (3) @(negedge clk);
    check(pin_oe_n, 18'h00000);
    check(pin_pullup_en, 18'h00000);
    periph_out = 20'hFFFFF;
    $display("test bus pins done");
  endtask
  // Analog pin skipped, open-drain GPIO, then pull-ups disabled
  task automatic t_analog;
    ext_drive = 18'h00008;
    ext_val = 18'h00008;
    cfg(18'h3FFF7, 18'h00000, 16'h0008, 8'h00, 8'h00, 8'h40);
    check(pin_analog_en, 18'h00008);
    check(pin_oe_n, 18'h2AAAA);
    check(pin_pullup_en, 18'h2AAA2);
    check(port_latch_rd, 18'h2AAA2);
    cfg(18'h3FFF7, 18'h00000, 16'h0008, 8'h00, 8'h80, 8'h40);
    check(pin_pullup_en, 18'h00000);
    $display("test analog done");
  endtask
  // Clock output and two capture channels take the next free pins
  task automatic t_pca;
    periph_drive = 20'h00000;
    ext_drive = 18'h0001E;
    ext_val = 18'h0000A;
    cfg(18'h3FFFF, 18'h3FFFF, 16'h0001, 8'h80, 8'h06, 8'h40);
    check(pin_oe_n, 18'h0001E);
    check(periph_in, 20'h05000);
    $display("test capture channels done");
  endtask
  // Debug line owns its pin with routing off; bank drive follows select
  task automatic t_debug;
    debug_active = 1'b1;
    debug_data_drive = 1'b1;
    debug_data_out = 1'b1;
    bank_drive_sel = 3'h5;
    cfg(18'h3FFFF, 18'h3FFFF, 16'h0000, 8'h00, 8'h00, 8'h00);
    check(pin_oe_n, 18'h2FFFF);
    check(debug_data_in, 1'b1);
    check(bank_drive_high, 3'h5);
    $display("test debug done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    port_latch_wr = 18'h2AAAA;
    periph_out = 20'hFFFFF;
    periph_drive = 20'h00000;
    {ext_val, ext_drive} = '0;
    {debug_active, debug_data_out, debug_data_drive} = 3'h0;
    bank_drive_sel = 3'h0;
    cfg(18'h3FFFF, 18'h00000, 16'h0000, 8'h00, 8'h00, 8'h00);
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    t_reset;
    t_walk;
    t_smbus;
    t_analog;
    t_pca;
    t_debug;
    conclude;
  end
endmodule
`default_nettype wire
